// file: verilog/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;

    // ***************************************************
    // Clock and timing
    // ***************************************************
    localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
    localparam real         TAD_MIN_US     = 1.6;
    // Least cycles of pclk in one conversion clock period
    localparam int unsigned TAD_MIN_CYCLES = int'($ceil(TAD_MIN_US * real'(CLK_FREQ_HZ) / 1.0e6));
    localparam int unsigned CONV_TADS      = 11;
    localparam int unsigned RESULT_W       = 10;

    // ***************************************************
    // Register indices (byte address is four times these)
    // ***************************************************
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
    localparam logic [7:0] IDX_CTRL_FIRST  = 8'h1F;
    localparam logic [7:0] IDX_PORT_DIR    = 8'h85;
    localparam logic [7:0] IDX_ANALOG_SEL  = 8'h91;
    localparam logic [7:0] IDX_RESULT_LOW  = 8'h9E;
    localparam logic [7:0] IDX_CTRL_SECOND = 8'h9F;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'hA0;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'hA1;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int unsigned CF_ENABLE  = 0;
    localparam int unsigned CF_START   = 1;
    localparam int unsigned CF_CHAN_LO = 2;
    localparam int unsigned CF_REF     = 6;
    localparam int unsigned CF_JUSTIFY = 7;
    localparam int unsigned CS_CLK_LO  = 4;
    localparam int unsigned CS_SHORT   = 0;
    localparam int unsigned IRQ_DONE   = 0;

    // ***************************************************
    // Reset values
    // ***************************************************
    localparam logic [7:0] RST_CTRL_FIRST  = 8'h00;
    localparam logic [7:0] RST_CTRL_SECOND = 8'h00;
    localparam logic [5:0] RST_PORT_DIR    = 6'h3F;
    localparam logic [7:0] RST_ANALOG_SEL  = 8'hFF;
    localparam logic [7:0] RST_IRQ_MASK    = 8'h00;

    // ***************************************************
    // Conversion clock sources
    // ***************************************************
    typedef enum logic [2:0] {
        CLK_DIV2  = 3'b000,
        CLK_DIV4  = 3'b001,
        CLK_DIV8  = 3'b010,
        CLK_DIV16 = 3'b011,
        CLK_DIV32 = 3'b100,
        CLK_DIV64 = 3'b101,
        CLK_RC    = 3'b110,
        CLK_RC_B  = 3'b111
    } clk_sel_e;

    // Sequencer states
    typedef enum logic [0:0] {
        SAR_IDLE = 1'b0,
        SAR_CONV = 1'b1
    } sar_state_e;

endpackage
`default_nettype wire

// file: verilog/conv_clock_gen.sv
`timescale 1ns/10ps
`default_nettype none
module conv_clock_gen
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Source choice and RC pin
    input  wire logic [2:0] clk_sel,
    input  wire logic       rc_clock_pin,
    // One pulse per conversion clock period
    output logic            tick
);

    logic [5:0] div_cnt;   // Free running divider
    logic [5:0] div_mask;  // Ratio minus one
    logic       rc_s1;     // Synchroniser, first stage
    logic       rc_s2;     // Second stage
    logic       rc_s3;     // Third stage
    logic       rc_lvl;    // Accepted RC level
    logic       rc_rise;   // Agreed rising edge
    logic       div_hit;   // Divider wraps this cycle
    logic       next_tick;

    // ***************************************************
    // Source decode
    // ***************************************************
    assign div_mask  = 6'((7'h02 << clk_sel) - 7'h01);
    assign div_hit   = (div_cnt & div_mask) == div_mask;
    // Edge counts only once stages two and three agree
    assign rc_rise   = (rc_s2 == rc_s3) && rc_s3 && !rc_lvl;
    assign next_tick = (clk_sel[2:1] == 2'b11) ? rc_rise : div_hit;

    // Divider counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 6'h00;
        end else if (ce) begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // RC clock synchroniser; the pin is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_s1  <= 1'b0;
            rc_s2  <= 1'b0;
            rc_s3  <= 1'b0;
            rc_lvl <= 1'b0;
        end else if (ce) begin
            rc_s1 <= rc_clock_pin;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
            if (rc_s2 == rc_s3) begin
                rc_lvl <= rc_s3;
            end
        end
    end

    // Registered tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else if (ce) begin
            tick <= next_tick;
        end
    end

endmodule
`default_nettype wire

// file: verilog/sar_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module sar_sequencer
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // Control
    input  wire logic                run,
    input  wire logic                tick,
    input  wire logic                comp_high,
    // Front end and result
    output logic                     sample_hold,
    output logic [RESULT_W-1:0]      dac_code,
    output logic [RESULT_W-1:0]      result,
    output logic                     done
);

    sar_state_e          state;
    sar_state_e          next_state;
    logic [3:0]          period;      // Conversion periods seen so far
    logic [3:0]          bit_idx;     // Bit decided this period
    logic [RESULT_W-1:0] next_code;
    logic                last_period;

    // ***************************************************
    // Trial code update
    // ***************************************************
    assign bit_idx     = 4'(RESULT_W) - period;
    assign last_period = period == 4'(CONV_TADS - 1);

    // Keep or drop the bit under test, then try the next one
    always_comb begin
        next_code = dac_code;
        if (period != 4'h0) begin
            next_code[bit_idx] = comp_high;
            if (bit_idx != 4'h0) begin
                next_code[bit_idx - 4'h1] = 1'b1;
            end
        end else begin
            next_code = 10'h200;
        end
    end

    // State choice; dropping run aborts
    always_comb begin
        next_state = state;
        unique case (state)
            SAR_IDLE: begin
                if (run) begin
                    next_state = SAR_CONV;
                end
            end
            SAR_CONV: begin
                if (!run || (tick && last_period)) begin
                    next_state = SAR_IDLE;
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= SAR_IDLE;
            period      <= 4'h0;
            sample_hold <= 1'b0;
            dac_code    <= 10'h000;
            result      <= 10'h000;
            done        <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            done  <= 1'b0;
            if (state == SAR_IDLE || !run) begin
                period      <= 4'h0;
                sample_hold <= 1'b0;
            end else if (tick) begin
                // First period opens the hold, ten more decide bits
                dac_code    <= next_code;
                sample_hold <= !last_period;
                period      <= last_period ? 4'h0 : period + 4'h1;
                if (last_period) begin
                    result <= next_code;
                    done   <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: verilog/sar_adc_control.sv
// Behaviour
// - Successive approximation into 10-bit result register
// - Channel field bits 4:2 picks input
// - Bit 6 set selects external reference
// - Conversion lasts exactly 11 conversion periods
// - Clock field bits 6:4 picks divider/RC
// - Analog-select bits disable pin digital buffers
// - Direction bit set floats pin driver
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)(
    // Clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Analog front end
    input  wire logic              comp_high_pin,
    input  wire logic              rc_clock_pin,
    output logic [2:0]             channel_select_field,
    output logic                   reference_select_bit,
    output logic                   sample_hold,
    output logic [RESULT_W-1:0]    dac_code,
    // Pin control
    output logic [7:0]             analog_select_bits,
    output logic [5:0]             port_a_high_z,
    // Interrupt
    output logic                   irq
);

    // ***************************************************
    // Declarations
    // ***************************************************
    logic                conv_enable;     // Converter powered
    logic                start_bit;       // Conversion in progress
    logic                justify_left;    // Result alignment
    logic [2:0]          clk_sel;         // Conversion clock source
    logic [7:0]          irq_status;      // Sticky events
    logic [7:0]          irq_mask;        // Enables onto irq
    logic [RESULT_W-1:0] result;          // From sequencer
    logic                conv_done;       // One-cycle pulse
    logic                tad_tick;        // Conversion clock pulse
    logic                comp_s1;         // Comparator sync stage one
    logic                comp_s2;         // Stage two
    logic                comp_s3;         // Stage three
    logic                comp_lvl;        // Accepted comparator level
    logic [7:0]          read_mux;        // Selected read byte
    logic [7:0]          result_high;
    logic [7:0]          result_low;
    logic [7:0]          ctrl_first_rd;
    logic [7:0]          ctrl_second_rd;
    logic                tad_short;       // Period below the minimum
    logic [7:0]          reg_idx;
    logic                aligned;
    logic                mapped;
    logic                setup;
    logic                access;
    logic                wr_en;
    logic                rd_en;
    logic [7:0]          wbyte;
    logic                wr_first;
    logic [7:0]          next_status;

    // ***************************************************
    // Bus decode
    // ***************************************************
    assign reg_idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr >> 10) == '0;
    assign mapped  = aligned && (reg_idx == IDX_RESULT_HIGH || reg_idx == IDX_CTRL_FIRST
                  || reg_idx == IDX_PORT_DIR || reg_idx == IDX_ANALOG_SEL
                  || reg_idx == IDX_RESULT_LOW || reg_idx == IDX_CTRL_SECOND
                  || reg_idx == IDX_IRQ_STATUS || reg_idx == IDX_IRQ_MASK);
    assign setup   = psel && !penable;
    // Access completes at the edge where our registered pready is high
    assign access  = psel && penable && pready;
    assign wr_en   = access && pwrite && mapped && pstrb[0];
    assign rd_en   = access && !pwrite && mapped;
    assign wbyte   = pwdata[7:0];
    assign wr_first = wr_en && reg_idx == IDX_CTRL_FIRST;

    // ***************************************************
    // Read data
    // ***************************************************
    // Alignment of the ten result bits over two bytes
    assign result_high = justify_left ? result[9:2] : {6'h00, result[9:8]};
    assign result_low  = justify_left ? {result[1:0], 6'h00} : result[7:0];

    // At 250 MHz only the RC source can meet the minimum period
    assign tad_short = (clk_sel[2:1] != 2'b11)
                    && ((32'h2 << clk_sel) < TAD_MIN_CYCLES);

    assign ctrl_first_rd  = {justify_left, reference_select_bit, 1'b0,
                             channel_select_field, start_bit, conv_enable};
    assign ctrl_second_rd = {1'b0, clk_sel, 3'b000, tad_short};

    assign read_mux = (reg_idx == IDX_RESULT_HIGH) ? result_high
                    : (reg_idx == IDX_CTRL_FIRST)  ? ctrl_first_rd
                    : (reg_idx == IDX_PORT_DIR)    ? {2'b00, port_a_high_z}
                    : (reg_idx == IDX_ANALOG_SEL)  ? analog_select_bits
                    : (reg_idx == IDX_RESULT_LOW)  ? result_low
                    : (reg_idx == IDX_CTRL_SECOND) ? ctrl_second_rd
                    : (reg_idx == IDX_IRQ_STATUS)  ? irq_status
                    : (reg_idx == IDX_IRQ_MASK)    ? irq_mask
                    : 8'h00;

    // ***************************************************
    // Interrupt status
    // ***************************************************
    // Only bits shown to the reader are cleared; a new event still wins
    assign next_status = (rd_en && reg_idx == IDX_IRQ_STATUS)
                       ? ((irq_status & ~prdata[7:0]) | {7'h00, conv_done})
                       : (irq_status | {7'h00, conv_done});

    // ***************************************************
    // APB response
    // ***************************************************
    // One wait-free access phase; data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_mux};
            end
        end
    end

    // ***************************************************
    // Control registers
    // ***************************************************
    // Configuration written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_enable          <= RST_CTRL_FIRST[CF_ENABLE];
            channel_select_field <= RST_CTRL_FIRST[CF_CHAN_LO +: 3];
            reference_select_bit <= RST_CTRL_FIRST[CF_REF];
            justify_left         <= RST_CTRL_FIRST[CF_JUSTIFY];
            clk_sel              <= RST_CTRL_SECOND[CS_CLK_LO +: 3];
            analog_select_bits   <= RST_ANALOG_SEL;
            port_a_high_z        <= RST_PORT_DIR;
            irq_mask             <= RST_IRQ_MASK;
        end else if (ce && wr_en) begin
            if (reg_idx == IDX_CTRL_FIRST) begin
                conv_enable          <= wbyte[CF_ENABLE];
                channel_select_field <= wbyte[CF_CHAN_LO +: 3];
                reference_select_bit <= wbyte[CF_REF];
                justify_left         <= wbyte[CF_JUSTIFY];
            end
            if (reg_idx == IDX_CTRL_SECOND) begin
                clk_sel <= wbyte[CS_CLK_LO +: 3];
            end
            if (reg_idx == IDX_ANALOG_SEL) begin
                analog_select_bits <= wbyte;
            end
            if (reg_idx == IDX_PORT_DIR) begin
                port_a_high_z <= wbyte[5:0];
            end
            if (reg_idx == IDX_IRQ_MASK) begin
                irq_mask <= wbyte;
            end
        end
    end

    // Start bit: software sets or aborts, completion clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_bit <= RST_CTRL_FIRST[CF_START];
        end else if (ce) begin
            if (wr_first) begin
                // A write in the completion cycle wins
                start_bit <= wbyte[CF_START] && wbyte[CF_ENABLE];
            end else if (conv_done) begin
                start_bit <= 1'b0;
            end
        end
    end

    // Sticky status and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 8'h00;
            irq        <= 1'b0;
        end else if (ce) begin
            irq_status <= next_status;
            irq        <= |(next_status & irq_mask);
        end
    end

    // ***************************************************
    // Comparator synchroniser
    // ***************************************************
    // Analog decision is asynchronous; accept it once stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_s1  <= 1'b0;
            comp_s2  <= 1'b0;
            comp_s3  <= 1'b0;
            comp_lvl <= 1'b0;
        end else if (ce) begin
            comp_s1 <= comp_high_pin;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3) begin
                comp_lvl <= comp_s3;
            end
        end
    end

    // ***************************************************
    // Conversion clock and sequencer
    // ***************************************************
    conv_clock_gen u_clock (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .clk_sel      (clk_sel),
        .rc_clock_pin (rc_clock_pin),
        .tick         (tad_tick)
    );

    // Comparator settling plus sync needs several pclk per period
    sar_sequencer u_sar (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .run         (start_bit && conv_enable),
        .tick        (tad_tick),
        .comp_high   (comp_lvl),
        .sample_hold (sample_hold),
        .dac_code    (dac_code),
        .result      (result),
        .done        (conv_done)
    );

endmodule
`default_nettype wire

// file: dv/adc_front_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_front_model (
    // Clock and trial code
    input  wire logic       pclk,
    input  wire logic       sample_hold,
    input  wire logic [9:0] dac_code,
    // Analog level and response speed
    input  wire logic [9:0] level,
    input  wire logic       slow,
    // Comparator decision
    output logic            comp_high_pin
);
    // *****
    // Comparator
    // *****
    logic [2:0] pipe = 3'h0;  // Decision delay line
    // Code settles on level
    always @(posedge pclk) begin
        if (!sample_hold) begin
            pipe <= {pipe[1:0], ~pipe[0]};  // Meaningless while sampling
        end else begin
            pipe <= {pipe[1:0], dac_code <= level};
        end
    end
    // Slow mode for RC only
    assign comp_high_pin = slow ? pipe[2] : pipe[0];
endmodule
`default_nettype wire

// file: dv/sar_adc_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_checker
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
)(
    // Clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                ce,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic                pready,
    input wire logic                pslverr,
    // Converter and pins
    input wire logic [2:0]          channel_select_field,
    input wire logic                reference_select_bit,
    input wire logic                sample_hold,
    input wire logic [RESULT_W-1:0] dac_code,
    input wire logic [7:0]          analog_select_bits,
    input wire logic [5:0]          port_a_high_z,
    input wire logic                irq
);
    // *****
    // Helper state
    // *****
    logic [7:0]  wdata_q;   // Last write byte
    logic [2:0]  sel_q;     // Clock source
    logic        mask_q;    // Done mask
    logic        setup_q;   // Setup, delayed
    logic [15:0] hold_cnt;  // Hold cycles
    wire         setup  = psel && !penable && ce;
    wire [7:0]   idx    = paddr[9:2];
    wire         acc_wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
    // Hold lasts ten periods
    wire [15:0]  hold_exp = 16'(10 << (sel_q + 3'h1));
    // Shadows of completed writes, plus delayed write byte, setup and hold count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_q  <= 8'h00;
            sel_q    <= 3'h0;
            mask_q   <= 1'b0;
            setup_q  <= 1'b0;
            hold_cnt <= 16'h0;
        end else begin
            wdata_q  <= pwdata[7:0];
            setup_q  <= setup;
            hold_cnt <= sample_hold ? hold_cnt + 16'h1 : 16'h0;
            if (acc_wr && idx == IDX_CTRL_SECOND) begin
                sel_q <= pwdata[6:4];
            end
            if (acc_wr && idx == IDX_IRQ_MASK) begin
                mask_q <= pwdata[0];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence reg_write(logic [7:0] i);
        acc_wr && idx == i;
    endsequence
    sequence conv_end;
        $fell(sample_hold) ##0 mask_q;
    endsequence
    // *****
    // Assertions
    // *****
    a_ready_after_setup: assert property (setup |=> pready) else $error("no ready");
    a_ready_only_access: assert property (pready |-> setup_q && psel && penable) else $error("stray ready");
    a_err_misaligned: assert property (setup && (paddr[1:0] != 2'b00 || idx == 8'h10) |=> pslverr)
        else $error("no error");
    a_chan_follows_write: assert property (reg_write(IDX_CTRL_FIRST) |=> channel_select_field == wdata_q[4:2])
        else $error("channel");
    a_ref_follows_write: assert property (reg_write(IDX_CTRL_FIRST) |=> reference_select_bit == wdata_q[6])
        else $error("reference");
    a_analog_sel_write: assert property (reg_write(IDX_ANALOG_SEL) |=> analog_select_bits == wdata_q)
        else $error("analog select");
    a_dir_follows_write: assert property (reg_write(IDX_PORT_DIR) |=> port_a_high_z == wdata_q[5:0])
        else $error("direction");
    a_trial_starts_mid: assert property ($rose(sample_hold) |-> dac_code == 10'h200)
        else $error("first code");
    a_conv_length: assert property ($fell(sample_hold) && sel_q < 3'h6 |-> hold_cnt == hold_exp)
        else $error("length");
    a_irq_after_done: assert property (conv_end |-> ##[0:2] irq) else $error("no interrupt");
    a_irq_needs_mask: assert property (irq |-> mask_q || $past(mask_q)) else $error("masked interrupt");
endmodule
bind sar_adc_control sar_adc_control_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .channel_select_field, .reference_select_bit,
    .sample_hold, .dac_code, .analog_select_bits, .port_a_high_z, .irq);
`default_nettype wire

// file: dv/test_sar_adc_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_sar_adc_control
    import adc_ctrl_pkg::*;
;
    // *****
    // Stimulus and observed signals
    // *****
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        rc_clock_pin = 0, slow = 0;
    logic [9:0]  level = 10'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, comp_high_pin, reference_select_bit, sample_hold, irq;
    wire  [2:0]  channel_select_field;
    wire  [9:0]  dac_code;
    wire  [7:0]  analog_select_bits;
    wire  [5:0]  port_a_high_z;
    logic [32:0] expq[$];          // Notes {error, data}
    logic [32:0] exp_v;
    logic [7:0]  v, ctl;
    logic [2:0]  sel;
    int          err_count = 0, total_checks = 0, n;
    always #2 pclk = ~pclk;
    // RC source, 400-cycle period
    always begin
        repeat (200) @(posedge pclk);
        rc_clock_pin <= ~rc_clock_pin;
    end
    sar_adc_control u_sar_adc_control (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .comp_high_pin, .rc_clock_pin, .irq, .channel_select_field,
        .reference_select_bit, .sample_hold, .dac_code, .analog_select_bits, .port_a_high_z);
    adc_front_model u_adc_front_model (.pclk, .sample_hold, .dac_code, .level, .slow, .comp_high_pin);
    // Oldest note per completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp_v = expq.pop_front();
            `CHK({pslverr, prdata}, exp_v)
        end
    end
    // One APB transfer, held until ready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'($urandom), d};
        if (!wr) expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00, {25'h0, e});
    endtask
    task automatic hold_is(input logic h);
        for (n = 0; n < 9000 && sample_hold !== h; n++) @(posedge pclk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hA8D7));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(analog_select_bits, 8'hFF)
        `CHK(port_a_high_z, 6'h3F)
        rd(IDX_PORT_DIR, 8'h3F);
        rd(IDX_ANALOG_SEL, 8'hFF);
        rd(IDX_CTRL_FIRST, 8'h00);
        rd(IDX_IRQ_MASK, 8'h00);
        apb(1'b0, 8'h10, 8'h00, {1'b1, 32'h0});
        $display("reset test done");
        // Pin control; last write has lane off
        v = 8'($urandom);
        wr(IDX_ANALOG_SEL, v);
        wr(IDX_PORT_DIR, v);
        pstrb <= 4'hE;
        wr(IDX_PORT_DIR, ~v);
        pstrb <= 4'hF;
        rd(IDX_PORT_DIR, {2'b00, v[5:0]});
        rd(IDX_ANALOG_SEL, v);
        `CHK(analog_select_bits, v)
        `CHK(port_a_high_z, v[5:0])
        $display("pin test done");
        // Four dividers and RC; first masked
        for (int i = 0; i < 5; i++) begin
            sel = (i == 4) ? 3'h6 : 3'(i + 2);
            slow <= (sel == 3'h6);
            level <= 10'($urandom);
            ctl = {i[0], 1'($urandom), 1'b0, 3'($urandom), 2'b11};
            wr(IDX_IRQ_MASK, {7'h0, i != 0});
            wr(IDX_CTRL_SECOND, {1'b0, sel, 4'h0});
            rd(IDX_CTRL_SECOND, {1'b0, sel, 3'h0, sel != 3'h6});
            wr(IDX_CTRL_FIRST, ctl);
            hold_is(1'b1);
            hold_is(1'b0);
            repeat (3) @(posedge pclk);
            `CHK(channel_select_field, ctl[4:2])
            `CHK(reference_select_bit, ctl[6])
            `CHK(irq, 1'(i != 0))
            rd(IDX_CTRL_FIRST, ctl & 8'hFD);
            rd(IDX_RESULT_HIGH, ctl[7] ? level[9:2] : {6'h0, level[9:8]});
            rd(IDX_RESULT_LOW, ctl[7] ? {level[1:0], 6'h0} : level[7:0]);
            rd(IDX_IRQ_STATUS, 8'h01);
            repeat (2) @(posedge pclk);
            `CHK(irq, 1'b0)
            rd(IDX_IRQ_STATUS, 8'h00);
            $display("conversion test %0d done", i);
        end
        // Abort leaves no flag
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_CTRL_FIRST, 8'h03);
        hold_is(1'b1);
        wr(IDX_CTRL_FIRST, 8'h01);
        repeat (4000) @(posedge pclk);
        `CHK(sample_hold, 1'b0)
        rd(IDX_IRQ_STATUS, 8'h00);
        rd(IDX_CTRL_FIRST, 8'h01);
        $display("abort test done");
        complete_run();
    end
endmodule
`default_nettype wire
